// ==== rtl/pds_sequencer.sv ====
`timescale 1ns/100ps
// Behaviour
// - Manual: idle until detect command, run one detection, report, return idle.
// - Semi-auto: detect repeatedly, power only on host power-on command.
// - Detection status refreshed at the end of every detection cycle.
// - Outside manual mode, valid signature with class enabled leads to classification and class report.
// - Polling modes back off 100ms, or 2s in midspan, between cycles.
// - Semi-auto high power: power-on only with detection result good.
// - Semi-auto high power: power-on without good result raises inrush timeout fault.
// - Without high power, power-on command applies power regardless of detection.
// - Auto mode polls and powers itself after good detection and classification, unless a ping-pong second classification is not class 4.
// - Auto mode sets cut and limit thresholds from the discovered class.
// - Detection off with strap low at reset, shutdown, or detect enable clear.
// - Legacy detection off after reset, host enables per port.
// - Legacy on: resistive or high-capacitance counts good; off: resistive only.
// - Class is 0 to 4; class 0 treated as class 3.
// - Classification drives probe voltage 12ms, then samples and records the class.
// - Manual mode classifies only on explicit host class command.
// - Classification off with strap low at reset, shutdown, or class enable clear.
// - Ping-pong with class 4: mark voltage, brief pause, second classification.
// - Second classification sets the per-port second-event flag.
// - Ping-pong with first class 0 to 3: Type 1, no second cycle.
// - Host threshold updates accepted once the straps settle, including while powered; an auto power-up in the same cycle overrides them.
// - Mode encoding: 11 auto (strap high), 10 semi, 01 manual, 00 shutdown.
// - Good only if forced-current and forced-voltage both measure in window, or high-capacitance with legacy on.
// - Auto mode limit 425mA class 0-3, 850mA class 4, cut per class.
module pds_sequencer #(
	parameter int BACKOFF_CYCLES = pds_pkg::BACKOFF_CYCLES,
	parameter int MID_BACKOFF_CYCLES = pds_pkg::MID_BACKOFF_CYCLES,
	parameter int CLASS_PROBE_CYCLES = pds_pkg::CLASS_PROBE_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_auto_strap,
	input wire logic i_mid_strap,
	input wire logic [3:0] i_cfg_wr,
	input wire logic [3:0][1:0] i_port_op_mode,
	input wire logic [3:0] i_detect_en,
	input wire logic [3:0] i_class_en,
	input wire logic [3:0] i_legacy_en,
	input wire logic [3:0] i_high_power_en,
	input wire logic [3:0] i_ping_pong_en,
	input wire logic [3:0] i_thresh_wr,
	input wire logic [3:0][15:0] i_cut_mA,
	input wire logic [3:0][15:0] i_lim_mA,
	input wire logic [3:0] i_cmd_detect,
	input wire logic [3:0] i_cmd_class,
	input wire logic [3:0] i_cmd_power_on,
	input wire logic [3:0] i_cmd_power_off,
	input wire logic [3:0] i_fault_off,
	input wire logic [3:0] i_det_done,
	input wire logic [3:0][2:0] i_det_code,
	input wire logic [3:0] i_det_fc_good,
	input wire logic [3:0] i_det_fv_good,
	input wire logic [3:0][2:0] i_class_meas,
	output logic [3:0] o_det_start,
	output logic [3:0] o_class_probe_voltage,
	output logic [3:0] o_mark_voltage,
	output logic [3:0][2:0] o_detect_status,
	output logic [3:0][2:0] o_class_status,
	output logic [3:0] o_second_class_ran,
	output logic [3:0] o_power_on,
	output logic [3:0] o_inrush_timeout_fault,
	output logic [3:0][15:0] o_overcurrent_cut_threshold,
	output logic [3:0][15:0] o_current_limit_threshold
);
	localparam logic [27:0] BACKOFF_LOAD = 28'(BACKOFF_CYCLES - 1);
	localparam logic [27:0] MID_BACKOFF_LOAD = 28'(MID_BACKOFF_CYCLES - 1);
	localparam logic [27:0] PROBE_LOAD = 28'(CLASS_PROBE_CYCLES - 1);
	localparam logic [27:0] MARK_LOAD = 28'(pds_pkg::MARK_PAUSE_CYCLES - 1);

	pds_pkg::pds_state_all_t s_reg;
	pds_pkg::pds_state_all_t s_next;

	function automatic logic [15:0] cut_of(input logic [2:0] c);
		unique case (c)
			pds_pkg::CLASS_1: cut_of = pds_pkg::CUT_CLASS1;
			pds_pkg::CLASS_2: cut_of = pds_pkg::CUT_CLASS2;
			pds_pkg::CLASS_4: cut_of = pds_pkg::CUT_CLASS4;
			default: cut_of = pds_pkg::CUT_CLASS3; // Class 0 and 3 alike
		endcase
	endfunction : cut_of

	function automatic logic [15:0] lim_of(input logic [2:0] c);
		lim_of = (c == pds_pkg::CLASS_4) ? pds_pkg::LIM_TYPE2 : pds_pkg::LIM_TYPE1;
	endfunction : lim_of

	// Reserved auto code without the strap acts as shutdown
	function automatic logic [1:0] eff_mode(input logic [1:0] m, input logic strap);
		eff_mode = (m == pds_pkg::MODE_AUTO && !strap) ? pds_pkg::MODE_SHUTDOWN : m;
	endfunction : eff_mode

	// Timed states load N-1 and leave when the count reaches zero
	function automatic logic expired(input logic [27:0] t);
		expired = (t == 28'h0000000);
	endfunction : expired

	function automatic logic [27:0] count_down(input logic [27:0] t);
		count_down = t - 28'h0000001;
	endfunction : count_down

	always_comb begin
		pds_pkg::pds_port_t q;
		logic [1:0] m;
		logic fin;
		logic det_ok;
		logic cls_ok;
		logic [2:0] c;
		logic [2:0] dres;
		q = '0;
		m = pds_pkg::MODE_SHUTDOWN;
		fin = 1'b0;
		det_ok = 1'b0;
		cls_ok = 1'b0;
		c = pds_pkg::CLASS_0;
		dres = pds_pkg::DET_UNKNOWN;
		s_next = s_reg;
		s_next.strap_meta = i_auto_strap;
		s_next.strap_sync = s_reg.strap_meta;
		s_next.mid_meta = i_mid_strap;
		s_next.mid_sync = s_reg.mid_meta;
		if (!s_reg.ready) begin
			// Straps are only believed once the synchroniser has settled
			if (s_reg.settle == pds_pkg::STRAP_SETTLE) begin
				s_next.ready = 1'b1;
				s_next.auto_strap = s_reg.strap_sync;
				s_next.mid_strap = s_reg.mid_sync;
				for (int p = 0; p < pds_pkg::NUM_PORTS; p++) begin
					s_next.ports[p].mode = s_reg.strap_sync ? pds_pkg::MODE_AUTO
						: pds_pkg::MODE_SHUTDOWN;
					s_next.ports[p].det_en = s_reg.strap_sync;
					s_next.ports[p].cls_en = s_reg.strap_sync;
					s_next.ports[p].pp_en = s_reg.strap_sync;
				end
			end else begin
				s_next.settle = s_reg.settle + 2'h1;
			end
		end else begin
			for (int p = 0; p < pds_pkg::NUM_PORTS; p++) begin
				q = s_reg.ports[p];
				fin = 1'b0;
				q.det_start = 1'b0;
				q.fault = 1'b0;
				if (i_cfg_wr[p]) begin
					q.mode = i_port_op_mode[p];
					q.det_en = i_detect_en[p];
					q.cls_en = i_class_en[p];
					q.legacy_en = i_legacy_en[p];
					q.hp_en = i_high_power_en[p];
					q.pp_en = i_ping_pong_en[p];
				end
				if (i_thresh_wr[p]) begin
					q.cut = i_cut_mA[p];
					q.lim = i_lim_mA[p];
				end
				m = eff_mode(s_reg.ports[p].mode, s_reg.auto_strap);
				det_ok = s_reg.ports[p].det_en && m != pds_pkg::MODE_SHUTDOWN;
				cls_ok = s_reg.ports[p].cls_en && m != pds_pkg::MODE_SHUTDOWN;
				c = (i_class_meas[p] > pds_pkg::CLASS_4) ? pds_pkg::CLASS_0 : i_class_meas[p];
				unique case (s_reg.ports[p].st)
					pds_pkg::PDS_IDLE: begin
						if (m == pds_pkg::MODE_MANUAL) begin
							if (i_cmd_detect[p] && det_ok) begin
								q.st = pds_pkg::PDS_DETECT;
								q.det_start = 1'b1;
							end else if (i_cmd_class[p] && cls_ok) begin
								q.st = pds_pkg::PDS_CLASS1;
								q.timer = PROBE_LOAD;
								q.second = 1'b0;
							end
						end else if (m != pds_pkg::MODE_SHUTDOWN && det_ok) begin
							q.st = pds_pkg::PDS_DETECT;
							q.det_start = 1'b1;
						end
					end
					pds_pkg::PDS_DETECT: begin
						if (i_det_done[p]) begin
							if (i_det_fc_good[p] && i_det_fv_good[p]) begin
								dres = pds_pkg::DET_GOOD;
							end else if (i_det_code[p] == pds_pkg::DET_CPD_HIGH
								&& s_reg.ports[p].legacy_en) begin
								dres = pds_pkg::DET_GOOD;
							end else if (i_det_code[p] == pds_pkg::DET_GOOD) begin
								dres = pds_pkg::DET_UNKNOWN;
							end else begin
								dres = i_det_code[p];
							end
							q.det = dres;
							q.second = 1'b0;
							if (dres == pds_pkg::DET_GOOD && cls_ok
								&& m != pds_pkg::MODE_MANUAL) begin
								q.st = pds_pkg::PDS_CLASS1;
								q.timer = PROBE_LOAD;
							end else begin
								fin = 1'b1;
							end
						end
					end
					pds_pkg::PDS_CLASS1, pds_pkg::PDS_CLASS2: begin
						if (expired(s_reg.ports[p].timer)) begin
							q.cls = c;
							if (s_reg.ports[p].st == pds_pkg::PDS_CLASS1 && s_reg.ports[p].pp_en
								&& c == pds_pkg::CLASS_4) begin
								q.st = pds_pkg::PDS_MARK;
								q.timer = MARK_LOAD;
							end else begin
								fin = 1'b1;
							end
						end else begin
							q.timer = count_down(s_reg.ports[p].timer);
						end
					end
					pds_pkg::PDS_MARK: begin
						if (expired(s_reg.ports[p].timer)) begin
							q.st = pds_pkg::PDS_CLASS2;
							q.timer = PROBE_LOAD;
							q.second = 1'b1;
						end else begin
							q.timer = count_down(s_reg.ports[p].timer);
						end
					end
					pds_pkg::PDS_BACKOFF: begin
						if (expired(s_reg.ports[p].timer)) begin
							q.st = pds_pkg::PDS_IDLE;
						end else begin
							q.timer = count_down(s_reg.ports[p].timer);
						end
					end
					pds_pkg::PDS_POWERED: begin
						// Held until power-off, fault or shutdown
					end
					default: begin
						// Unused state code recovers through idle
						q.st = pds_pkg::PDS_IDLE;
					end
				endcase
				if (fin) begin
					if (m == pds_pkg::MODE_MANUAL) begin
						q.st = pds_pkg::PDS_IDLE;
					end else if (m == pds_pkg::MODE_AUTO && q.det == pds_pkg::DET_GOOD
						&& !(q.second && q.cls != pds_pkg::CLASS_4)) begin
						q.power = 1'b1;
						q.st = pds_pkg::PDS_POWERED;
						q.cut = cut_of(cls_ok ? q.cls : pds_pkg::CLASS_0);
						q.lim = lim_of(cls_ok ? q.cls : pds_pkg::CLASS_0);
					end else begin
						q.st = pds_pkg::PDS_BACKOFF;
						q.timer = s_reg.mid_strap ? MID_BACKOFF_LOAD : BACKOFF_LOAD;
					end
				end
				// Host power-on only outside auto; auto powers itself
				if (i_cmd_power_on[p] && !s_reg.ports[p].power
					&& (m == pds_pkg::MODE_SEMI || m == pds_pkg::MODE_MANUAL)) begin
					if (s_reg.ports[p].hp_en && m == pds_pkg::MODE_SEMI
						&& s_reg.ports[p].det != pds_pkg::DET_GOOD) begin
						q.fault = 1'b1;
					end else begin
						q.power = 1'b1;
						q.st = pds_pkg::PDS_POWERED;
						q.det_start = 1'b0;
					end
				end
				if (i_cmd_power_off[p] || i_fault_off[p] || m == pds_pkg::MODE_SHUTDOWN) begin
					q.power = 1'b0;
					q.det_start = 1'b0;
					if (m == pds_pkg::MODE_SHUTDOWN || s_reg.ports[p].power) begin
						q.st = pds_pkg::PDS_IDLE;
					end
				end
				s_next.ports[p] = q;
			end
		end
		if (!i_rst_b) begin
			s_next = '0;
			for (int p = 0; p < pds_pkg::NUM_PORTS; p++) begin
				s_next.ports[p].cut = pds_pkg::CUT_RESET;
				s_next.ports[p].lim = pds_pkg::LIM_RESET;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		s_reg <= s_next;
	end

	always_comb begin
		for (int p = 0; p < pds_pkg::NUM_PORTS; p++) begin
			o_det_start[p] = s_reg.ports[p].det_start;
			o_class_probe_voltage[p] = s_reg.ports[p].st == pds_pkg::PDS_CLASS1
				|| s_reg.ports[p].st == pds_pkg::PDS_CLASS2;
			o_mark_voltage[p] = s_reg.ports[p].st == pds_pkg::PDS_MARK;
			o_detect_status[p] = s_reg.ports[p].det;
			o_class_status[p] = s_reg.ports[p].cls;
			o_second_class_ran[p] = s_reg.ports[p].second;
			o_power_on[p] = s_reg.ports[p].power;
			o_inrush_timeout_fault[p] = s_reg.ports[p].fault;
			o_overcurrent_cut_threshold[p] = s_reg.ports[p].cut;
			o_current_limit_threshold[p] = s_reg.ports[p].lim;
		end
	end
endmodule : pds_sequencer

// ==== rtl/pds_pkg.sv ====
package pds_pkg;
	localparam int NUM_PORTS = 4;
	localparam int CLK_MHZ = 100;

	// Port operating modes
	localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
	localparam logic [1:0] MODE_MANUAL = 2'h1;
	localparam logic [1:0] MODE_SEMI = 2'h2;
	localparam logic [1:0] MODE_AUTO = 2'h3;

	// Detection status codes
	localparam logic [2:0] DET_UNKNOWN = 3'h0;
	localparam logic [2:0] DET_SHORT = 3'h1;
	localparam logic [2:0] DET_CPD_HIGH = 3'h2;
	localparam logic [2:0] DET_RSIG_LOW = 3'h3;
	localparam logic [2:0] DET_GOOD = 3'h4;
	localparam logic [2:0] DET_RSIG_HIGH = 3'h5;
	localparam logic [2:0] DET_OPEN = 3'h6;
	localparam logic [2:0] DET_VOLT_HIGH = 3'h7;

	localparam logic [2:0] CLASS_0 = 3'h0;
	localparam logic [2:0] CLASS_1 = 3'h1;
	localparam logic [2:0] CLASS_2 = 3'h2;
	localparam logic [2:0] CLASS_3 = 3'h3;
	localparam logic [2:0] CLASS_4 = 3'h4;

	// Thresholds in mA
	localparam logic [15:0] CUT_CLASS1 = 16'h0070;
	localparam logic [15:0] CUT_CLASS2 = 16'h00CE;
	localparam logic [15:0] CUT_CLASS3 = 16'h0177;
	localparam logic [15:0] CUT_CLASS4 = 16'h027E;
	localparam logic [15:0] LIM_TYPE1 = 16'h01A9;
	localparam logic [15:0] LIM_TYPE2 = 16'h0352;
	localparam logic [15:0] CUT_RESET = CUT_CLASS3;
	localparam logic [15:0] LIM_RESET = LIM_TYPE1;

	// Timing
	localparam int BACKOFF_MS = 100;
	localparam int MID_BACKOFF_MS = 2000;
	localparam int CLASS_PROBE_MS = 12;
	localparam int MARK_PAUSE_US = 10;
	localparam int BACKOFF_CYCLES = BACKOFF_MS * 1000 * CLK_MHZ;
	localparam int MID_BACKOFF_CYCLES = MID_BACKOFF_MS * 1000 * CLK_MHZ;
	localparam int CLASS_PROBE_CYCLES = CLASS_PROBE_MS * 1000 * CLK_MHZ;
	localparam int MARK_PAUSE_CYCLES = MARK_PAUSE_US * CLK_MHZ;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef enum logic [2:0] {
		PDS_IDLE,
		PDS_DETECT,
		PDS_CLASS1,
		PDS_MARK,
		PDS_CLASS2,
		PDS_BACKOFF,
		PDS_POWERED
	} pds_state_t;

	typedef struct packed {
		pds_state_t st;
		logic [27:0] timer;
		logic [2:0] det;
		logic [2:0] cls;
		logic second;
		logic power;
		logic fault;
		logic det_start;
		logic [1:0] mode;
		logic det_en;
		logic cls_en;
		logic legacy_en;
		logic hp_en;
		logic pp_en;
		logic [15:0] cut;
		logic [15:0] lim;
	} pds_port_t;

	typedef struct packed {
		pds_port_t [NUM_PORTS-1:0] ports;
		logic strap_meta;
		logic strap_sync;
		logic mid_meta;
		logic mid_sync;
		logic auto_strap;
		logic mid_strap;
		logic [1:0] settle;
		logic ready;
	} pds_state_all_t;
endpackage : pds_pkg

// ==== test/pds_pd_model.sv ====
`timescale 1ns/100ps
module pds_pd_model (
	input wire logic i_clock,
	input wire logic [3:0] i_det_start,
	input wire logic [3:0] i_probe,
	input wire logic [3:0] i_second,
	input wire logic [3:0][2:0] i_code,
	input wire logic [3:0][2:0] i_cls_a,
	input wire logic [3:0][2:0] i_cls_b,
	output logic [3:0] o_det_done,
	output logic [3:0][2:0] o_det_code,
	output logic [3:0] o_fc_good,
	output logic [3:0] o_fv_good,
	output logic [3:0][2:0] o_class_meas
);
	int wait_c [4] = '{default: 0};
	logic [2:0] tick = 3'h0;
	always @(posedge i_clock) begin
		tick <= tick + 3'h3;
		for (int p = 0; p < 4; p++) begin
			// Latency differs per port so prompt and slow answers both occur
			if (i_det_start[p])
				wait_c[p] <= 3 * p + 2;
			else if (wait_c[p] != 0)
				wait_c[p] <= wait_c[p] - 1;
			o_det_done[p] <= (wait_c[p] == 1);
		end
	end
	// Lines not being answered show a moving pattern, never a held value
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			o_det_code[p] = o_det_done[p] ? i_code[p] : tick;
			o_fc_good[p] = o_det_done[p] ? (i_code[p] == pds_pkg::DET_GOOD) : tick[0];
			o_fv_good[p] = o_fc_good[p];
			o_class_meas[p] = !i_probe[p] ? ~tick : (i_second[p] ? i_cls_b[p] : i_cls_a[p]);
		end
	end
endmodule : pds_pd_model

// ==== test/pds_asserts.sv ====
`timescale 1ns/100ps
module pds_asserts #(
	parameter int CLASS_PROBE_CYCLES = pds_pkg::CLASS_PROBE_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [3:0] i_det_done,
	input wire logic [3:0][2:0] i_det_code,
	input wire logic [3:0] i_det_fc_good,
	input wire logic [3:0] i_det_fv_good,
	input wire logic [3:0] o_class_probe_voltage,
	input wire logic [3:0] o_mark_voltage,
	input wire logic [3:0] o_det_start,
	input wire logic [3:0][2:0] o_detect_status,
	input wire logic [3:0][2:0] o_class_status,
	input wire logic [3:0] o_second_class_ran,
	input wire logic [3:0] o_power_on,
	input wire logic [3:0] o_inrush_timeout_fault
);
	int mark_cnt;
	int probe_cnt;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	always_ff @(posedge i_clock) begin
		if (!i_rst_b || !o_mark_voltage[0])
			mark_cnt <= 0;
		else
			mark_cnt <= mark_cnt + 1;
		if (!i_rst_b || !o_class_probe_voltage[0])
			probe_cnt <= 0;
		else
			probe_cnt <= probe_cnt + 1;
	end
	chk_probe_mark_excl: assert property ((o_class_probe_voltage & o_mark_voltage) == 4'h0)
		else $error("probe and mark voltage together");
	chk_start_pulse: assert property (o_det_start[0] |=> !o_det_start[0])
		else $error("detect start longer than one cycle");
	chk_status_good: assert property (i_det_done[0] && i_det_fc_good[0] && i_det_fv_good[0] &&
		i_det_code[0] == pds_pkg::DET_GOOD |=> o_detect_status[0] == pds_pkg::DET_GOOD)
		else $error("good detection not reported");
	chk_fault_pulse: assert property (o_inrush_timeout_fault[1] |=>
		!o_inrush_timeout_fault[1] && !o_power_on[1])
		else $error("inrush fault pulse wrong or port powered");
	chk_probe_len: assert property ($fell(o_class_probe_voltage[0]) |->
		probe_cnt == CLASS_PROBE_CYCLES)
		else $error("class probe length wrong");
	chk_mark_len: assert property ($fell(o_mark_voltage[0]) |->
		mark_cnt == pds_pkg::MARK_PAUSE_CYCLES)
		else $error("mark pause length wrong");
	chk_second_flag: assert property ($rose(o_second_class_ran[0]) |->
		$rose(o_class_probe_voltage[0]) && $past(o_mark_voltage[0]))
		else $error("second class flag not tied to second probe");
	chk_mark_after_four: assert property ($rose(o_mark_voltage[0]) |->
		o_class_status[0] == pds_pkg::CLASS_4)
		else $error("mark voltage without class 4");
	chk_power_good: assert property ($rose(o_power_on[0]) |->
		o_detect_status[0] == pds_pkg::DET_GOOD)
		else $error("auto power without good detection");
endmodule : pds_asserts
bind pds_sequencer pds_asserts #(.CLASS_PROBE_CYCLES(CLASS_PROBE_CYCLES)) u_chk (
	.i_clock(i_clock), .i_rst_b(i_rst_b), .i_det_done(i_det_done), .i_det_code(i_det_code),
	.i_det_fc_good(i_det_fc_good), .i_det_fv_good(i_det_fv_good),
	.o_class_probe_voltage(o_class_probe_voltage), .o_mark_voltage(o_mark_voltage),
	.o_det_start(o_det_start), .o_detect_status(o_detect_status),
	.o_class_status(o_class_status), .o_second_class_ran(o_second_class_ran),
	.o_power_on(o_power_on), .o_inrush_timeout_fault(o_inrush_timeout_fault));

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
	localparam int BO = 50;
	localparam int MBO = 100;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic auto_s = 1'b1;
	logic mid_s = 1'b0;
	logic [3:0] cfg_wr = 4'h0, det_en = 4'h0, cls_en = 4'h0, hp_en = 4'h0, pp_en = 4'h0;
	logic [3:0] th_wr = 4'h0, c_det = 4'h0, c_cls = 4'h0, c_on = 4'h0, saw_flt = 4'h0;
	logic [3:0] saw_prb = 4'h0, done, fcg, fvg, d_start, probe, mark, sec, pwr, flt;
	logic [3:0] leg_en = 4'h0;
	logic [3:0][1:0] op_mode = 8'h00;
	logic [3:0][15:0] cut = 64'h0, lim = 64'h0, o_cut, o_lim;
	logic [3:0][2:0] m_code = {3'h2, 3'h4, 3'h4, 3'h4}, m_a = {3'h0, 3'h4, 3'h0, 3'h4};
	logic [3:0][2:0] m_b = {3'h0, 3'h2, 3'h0, 3'h4}, dcode, cmeas, dstat, cstat;
	int n_mismatch = 0, checks = 0, cyc = 0;
	int n_start [4] = '{default: 0}, last [4] = '{default: 0}, gap [4] = '{default: 0};
	initial forever #5 i_clock = ~i_clock;
	pds_sequencer #(.BACKOFF_CYCLES(BO), .MID_BACKOFF_CYCLES(MBO), .CLASS_PROBE_CYCLES(20)) uut (
		.i_clock(i_clock), .i_rst_b(i_rst_b), .i_auto_strap(auto_s), .i_mid_strap(mid_s),
		.i_cfg_wr(cfg_wr), .i_port_op_mode(op_mode), .i_detect_en(det_en), .i_class_en(cls_en),
		.i_legacy_en(leg_en), .i_high_power_en(hp_en), .i_ping_pong_en(pp_en), .i_thresh_wr(th_wr),
		.i_cut_mA(cut), .i_lim_mA(lim), .i_cmd_detect(c_det), .i_cmd_class(c_cls),
		.i_cmd_power_on(c_on), .i_cmd_power_off(4'h0), .i_fault_off(4'h0), .i_det_done(done),
		.i_det_code(dcode), .i_det_fc_good(fcg), .i_det_fv_good(fvg), .i_class_meas(cmeas),
		.o_det_start(d_start), .o_class_probe_voltage(probe), .o_mark_voltage(mark),
		.o_detect_status(dstat), .o_class_status(cstat), .o_second_class_ran(sec),
		.o_power_on(pwr), .o_inrush_timeout_fault(flt), .o_overcurrent_cut_threshold(o_cut),
		.o_current_limit_threshold(o_lim));
	pds_pd_model pd (.i_clock(i_clock), .i_det_start(d_start), .i_probe(probe), .i_second(sec),
		.i_code(m_code), .i_cls_a(m_a), .i_cls_b(m_b), .o_det_done(done), .o_det_code(dcode),
		.o_fc_good(fcg), .o_fv_good(fvg), .o_class_meas(cmeas));
	always @(posedge i_clock) begin
		cyc++;
		for (int p = 0; p < 4; p++) begin
			if (d_start[p] === 1'b1) begin
				n_start[p]++;
				gap[p] = cyc - last[p];
				last[p] = cyc;
			end
			saw_flt[p] |= flt[p] === 1'b1;
			saw_prb[p] |= probe[p] === 1'b1;
		end
	end
	task give_verdict;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : step
	function automatic logic hit(input int s, input int p);
		case (s)
			0: return pwr[p];
			2: return dstat[p] !== 3'h0;
			default: return probe[p];
		endcase
	endfunction : hit
	task wait_on(input int s, input int p, input int lim_c);
		int k;
		k = 0;
		while (hit(s, p) !== 1'b1) begin
			step(1);
			k++;
			if (k > lim_c) begin
				n_mismatch++;
				give_verdict();
			end
		end
	endtask : wait_on
	task rst(input logic a, input logic m);
		@(posedge i_clock);
		i_rst_b <= 1'b0;
		auto_s <= a;
		mid_s <= m;
		repeat (6) @(posedge i_clock);
		i_rst_b <= 1'b1;
		step(8);
		n_start = '{default: 0};
		saw_flt = 4'h0;
		saw_prb = 4'h0;
	endtask : rst
	// Enable bits in en: pp, hp, cls, det from high to low
	task cfg(input int p, input logic [1:0] m, input logic [3:0] en);
		@(posedge i_clock);
		op_mode[p] <= m;
		{pp_en[p], hp_en[p], cls_en[p], det_en[p]} <= en;
		cfg_wr[p] <= 1'b1;
		@(posedge i_clock);
		cfg_wr <= 4'h0;
	endtask : cfg
	task cmd(input int s, input int p);
		@(posedge i_clock);
		case (s)
			0: c_det[p] <= 1'b1;
			1: c_cls[p] <= 1'b1;
			2: c_on[p] <= 1'b1;
			default: th_wr[p] <= 1'b1;
		endcase
		@(posedge i_clock);
		{c_det, c_cls, c_on, th_wr} <= 16'h0000;
	endtask : cmd
	initial begin
		rst(1'b1, 1'b0);
		check(o_lim[0], pds_pkg::LIM_RESET);
		wait_on(0, 0, 3000);
		check(o_cut[0], pds_pkg::CUT_CLASS4);
		check(o_lim[0], pds_pkg::LIM_TYPE2);
		check(16'(sec[0]), 16'h0001);
		wait_on(0, 1, 100);
		check(o_cut[1], pds_pkg::CUT_CLASS3);
		check(16'(sec[1]), 16'h0000);
		step(20);
		check(16'({pwr[2], sec[2], cstat[2]}), 16'h000A);
		check(16'(dstat[3]), 16'h0002);
		check(16'(gap[3] >= BO && gap[3] < MBO), 16'h0001);
		@(posedge i_clock);
		cut[0] <= 16'h0123;
		cmd(3, 0);
		step(1);
		check(o_cut[0], 16'h0123);
		rst(1'b0, 1'b1);
		step(100);
		check(16'(n_start[0] + n_start[1] + n_start[2] + n_start[3]), 16'h0000);
		check(16'(saw_prb), 16'h0000);
		m_code[0] = pds_pkg::DET_CPD_HIGH;
		cfg(0, pds_pkg::MODE_MANUAL, 4'h3);
		step(50);
		check(16'(n_start[0]), 16'h0000);
		cmd(0, 0);
		step(20);
		check(16'(dstat[0]), 16'(pds_pkg::DET_CPD_HIGH));
		m_code[0] = pds_pkg::DET_GOOD;
		cmd(0, 0);
		step(60);
		check(16'({n_start[0][3:0], dstat[0], saw_prb[0]}), 16'h0028);
		cmd(1, 0);
		wait_on(3, 0, 10);
		step(30);
		check(16'({sec[0], cstat[0]}), 16'h0004);
		m_code[0] = pds_pkg::DET_CPD_HIGH;
		@(posedge i_clock);
		leg_en[0] <= 1'b1;
		cfg(0, pds_pkg::MODE_MANUAL, 4'hB);
		cmd(0, 0);
		step(20);
		check(16'(dstat[0]), 16'(pds_pkg::DET_GOOD));
		cmd(1, 0);
		step(1060);
		check(16'({sec[0], cstat[0]}), 16'h000C);
		m_code[1] = pds_pkg::DET_RSIG_LOW;
		cfg(1, pds_pkg::MODE_SEMI, 4'h5);
		wait_on(2, 1, 200);
		cmd(2, 1);
		step(3);
		check(16'({saw_flt[1], pwr[1]}), 16'h0002);
		m_code[2] = pds_pkg::DET_OPEN;
		cfg(2, pds_pkg::MODE_SEMI, 4'h1);
		wait_on(2, 2, 200);
		cmd(2, 2);
		step(3);
		check(16'({saw_flt[2], pwr[2]}), 16'h0001);
		m_code[3] = pds_pkg::DET_GOOD;
		m_a[3] = pds_pkg::CLASS_2;
		cfg(3, pds_pkg::MODE_SEMI, 4'h7);
		step(700);
		check(16'({pwr[3], cstat[3], dstat[3]}), 16'h0014);
		check(16'(gap[3] >= MBO), 16'h0001);
		cmd(2, 3);
		step(3);
		check(16'(pwr[3]), 16'h0001);
		check(o_cut[3], pds_pkg::CUT_RESET);
		give_verdict();
	end
endmodule : tb
